// File: design/afrc_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes a single clock and an asynchronous active-low reset.
`timescale 1ns/1ps
module afrc_fifo #(
    parameter int WIDTH = 96,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW-1:0] rd_next;
    logic [AW:0] count;
    logic push;
    logic pop;

    // Handshake terms
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign in_ready = count != (AW+1)'(DEPTH);
    // Slot after the presented word, so a pop refills with fresh data
    assign rd_next = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);

    // Storage write
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // Pointers and fill level
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_next;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // Registered read side, refilled when empty or consumed
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_data <= '0;
            out_valid <= 1'b0;
        end else if (!out_valid || out_ready) begin
            out_valid <= 1'b0;
            if (count != '0 && !(pop && count == (AW+1)'(1))) begin
                out_data <= pop ? mem[rd_next] : mem[rd_ptr];
                out_valid <= 1'b1;
            end
        end
    end
endmodule

// File: design/afrc_host.sv
// Host that reads one converter frame per data-ready event and checks its CRC.
// Assumes data_ready_n and MISO arrive asynchronously; SCLK is made here by division.
`timescale 1ns/1ps
module afrc_host (
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic DATA_READY_N,
    input wire logic MISO,
    output afrc_pkg::afrc_spi_s SPI,
    output afrc_pkg::afrc_samples_s SAMPLES,
    output logic SAMPLES_VALID,
    input wire logic SAMPLES_READY,
    output logic CRC_ERROR,
    input wire logic CRC_ERROR_CLR,
    output logic BUSY
);
    import afrc_pkg::*;

    afrc_state_e state;
    logic [1:0] data_ready_n_sync;
    logic [1:0] miso_sync;
    logic data_ready_n_prev;
    logic data_ready_n_fall;
    logic [7:0] div_cnt;
    logic sclk;
    logic tick;
    logic [2:0] bit_cnt;
    logic [4:0] byte_cnt;
    logic [7:0] tx_byte;
    logic [7:0] rx_byte;
    logic [7:0] rx_full;
    logic [15:0] crc;
    logic [15:0] next_crc;
    logic [15:0] crc_rx;
    afrc_samples_s frame;
    afrc_samples_s hold;
    logic hold_new;
    logic fifo_ready;
    logic frame_ok;
    logic err_set;

    // Two-stage synchronisers for pin inputs
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            data_ready_n_sync <= 2'b11;
            miso_sync <= 2'b00;
            data_ready_n_prev <= 1'b1;
        end else begin
            data_ready_n_sync <= {data_ready_n_sync[0], DATA_READY_N};
            miso_sync <= {miso_sync[0], MISO};
            data_ready_n_prev <= data_ready_n_sync[1];
        end
    end

    // Readout is triggered by the falling edge only
    assign data_ready_n_fall = data_ready_n_prev && !data_ready_n_sync[1];

    // Byte CRC, MSB first, no final inversion
    always_comb begin
        next_crc = crc;
        for (int i = 7; i >= 0; i--) begin
            if (next_crc[15] ^ rx_byte[i]) begin
                next_crc = {next_crc[14:0], 1'b0} ^ CRC_POLY;
            end else begin
                next_crc = {next_crc[14:0], 1'b0};
            end
        end
    end

    // Last received byte including the bit just sampled
    assign rx_full = {rx_byte[6:0], miso_sync[1]};
    assign tick = (state == ST_SHIFT) && (div_cnt == 8'(HALF_DIV - 1));

    // Control sequence
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (data_ready_n_fall) begin
                        state <= ST_SAVE;
                    end
                end
                ST_SAVE: begin
                    state <= ST_SHIFT;
                end
                ST_SHIFT: begin
                    if (tick && sclk && bit_cnt == 3'd7 && byte_cnt == LAST_BYTE) begin
                        state <= ST_CHECK;
                    end
                end
                ST_CHECK: begin
                    state <= ST_DONE;
                end
                ST_DONE: begin
                    state <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Clock divider, mode 0: sample on rising, change on falling
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            div_cnt <= '0;
            sclk <= 1'b0;
        end else if (state != ST_SHIFT) begin
            div_cnt <= '0;
            sclk <= 1'b0;
        end else if (tick) begin
            div_cnt <= '0;
            sclk <= !sclk;
        end else begin
            div_cnt <= div_cnt + 8'd1;
        end
    end

    // Bit and byte counters, shift registers
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            bit_cnt <= '0;
            byte_cnt <= '0;
            tx_byte <= DUMMY_BYTE;
            rx_byte <= '0;
        end else if (state == ST_SAVE) begin
            bit_cnt <= '0;
            byte_cnt <= '0;
            tx_byte <= NULL_CMD[23:16];
            rx_byte <= '0;
        end else if (tick && !sclk) begin
            rx_byte <= rx_full; // Rising edge samples MISO
        end else if (tick && sclk) begin
            bit_cnt <= bit_cnt + 3'd1;
            if (bit_cnt == 3'd7) begin
                byte_cnt <= byte_cnt + 5'd1;
                // Command bytes first, then zero dummies for every read byte
                if (byte_cnt == 5'd0) begin
                    tx_byte <= NULL_CMD[15:8];
                end else if (byte_cnt == 5'd1) begin
                    tx_byte <= NULL_CMD[7:0];
                end else begin
                    tx_byte <= DUMMY_BYTE;
                end
            end else begin
                tx_byte <= {tx_byte[6:0], 1'b0};
            end
        end
    end

    // Per-byte capture: the byte is complete after its eighth rise, so read rx_byte
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            crc <= CRC_INIT;
            crc_rx <= '0;
            frame <= '0;
        end else if (state == ST_SAVE) begin
            crc <= CRC_INIT;
        end else if (tick && sclk && bit_cnt == 3'd7) begin
            if (byte_cnt < 5'(CRC_BYTES)) begin
                crc <= next_crc;
            end
            if (byte_cnt >= CH0_BYTE && byte_cnt < CRC_HI_BYTE) begin
                frame <= {rx_byte, frame[95:8]};
            end
            if (byte_cnt == CRC_HI_BYTE) begin
                crc_rx[15:8] <= rx_byte;
            end
            if (byte_cnt == CRC_LO_BYTE) begin
                crc_rx[7:0] <= rx_byte;
            end
        end
    end

    // Bytes arrive MSB first per word; reorder into channel words
    function automatic afrc_samples_s afrc_order(input afrc_samples_s f);
        afrc_samples_s r;
        r = '0;
        for (int c = 0; c < CHANNELS; c++) begin
            r[c*WORD_BITS +: WORD_BITS] = {f[c*WORD_BITS +: 8], f[c*WORD_BITS+8 +: 8],
                f[c*WORD_BITS+16 +: 8]};
        end
        return r;
    endfunction

    assign frame_ok = (crc == crc_rx);

    // Holding buffer updated only on a good frame
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            hold <= '0;
            hold_new <= 1'b0;
        end else begin
            if (state == ST_SAVE) begin
                hold_new <= 1'b0; // save of previous set into FIFO
            end
            if (state == ST_CHECK && frame_ok) begin
                hold <= afrc_order(frame);
                hold_new <= 1'b1;
            end
        end
    end

    // Sticky error flag; a new error wins over a clear
    assign err_set = (state == ST_CHECK) && !frame_ok;
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            CRC_ERROR <= 1'b0;
        end else if (err_set) begin
            CRC_ERROR <= 1'b1;
        end else if (CRC_ERROR_CLR) begin
            CRC_ERROR <= 1'b0;
        end
    end

    // Pin outputs
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            SPI <= '{sclk: 1'b0, cs_n: 1'b1, mosi: 1'b0};
            BUSY <= 1'b0;
        end else begin
            SPI.sclk <= sclk;
            SPI.cs_n <= !(state == ST_SHIFT);
            SPI.mosi <= tx_byte[7];
            BUSY <= state != ST_IDLE;
        end
    end

    // Saved set queued ahead of the new transfer
    afrc_fifo #(
        .WIDTH(4 * WORD_BITS),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(MCLK),
        .rst_n(RST_N),
        .in_data(hold),
        .in_valid(state == ST_SAVE && hold_new),
        .in_ready(fifo_ready),
        .out_data(SAMPLES),
        .out_valid(SAMPLES_VALID),
        .out_ready(SAMPLES_READY)
    );
endmodule

// File: design/afrc_pkg.sv
// Constants and carrier types for the converter frame readout host.
// Assumes one 100 MHz system clock; the link is a full-duplex SPI master.
// How it works
// - On that edge host first saves held samples, then lowers chip select.
// - Frame is six three-byte words each way, shifted full-duplex.
// - First word sent is the null command, all zeros.
// - Host may discard the first received word.
// - Host sends a zero dummy byte for every byte it reads.
// - Host still clocks the zero padding byte of the checksum word.
// - Host computes CRC over the first 15 received bytes, in arrival order.
// - CRC register starts at all ones for each frame.
// - Received checksum is bytes 16 and 17; byte 18 ignored.
// - On match the four channel values go to holding buffers for next event.
// - Host raises chip select after the frame, before the next data-ready.
// - Readout is pipelined: transfer N-1 while converter acquires N, host uses N-2.
package afrc_pkg;
    localparam int CLK_HZ = 100_000_000;
    localparam int SCLK_HZ = 12_500_000;
    localparam int HALF_DIV = CLK_HZ / (2 * SCLK_HZ);
    localparam int OSR_MOD_CYCLES = 512;
    localparam int WORD_BITS = 24;
    localparam int WORDS = 6;
    localparam int BYTES = 18;
    localparam int CRC_BYTES = 15;
    localparam int CHANNELS = 4;
    localparam int FIFO_DEPTH = 16;
    localparam logic [7:0] DUMMY_BYTE = 8'h00;
    localparam logic [23:0] NULL_CMD = 24'h00_0000;
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam logic [15:0] CRC_POLY = 16'h1021;
    localparam logic [4:0] CRC_HI_BYTE = 5'd15;
    localparam logic [4:0] CRC_LO_BYTE = 5'd16;
    localparam logic [4:0] LAST_BYTE = 5'd17;
    localparam logic [4:0] CH0_BYTE = 5'd3;

    typedef logic [WORD_BITS-1:0] afrc_word_t;

    // One buffered sample set
    typedef struct packed {
        afrc_word_t ch3;
        afrc_word_t ch2;
        afrc_word_t ch1;
        afrc_word_t ch0;
    } afrc_samples_s;

    // SPI pins driven by the host
    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic mosi;
    } afrc_spi_s;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b0_0001,
        ST_SAVE = 5'b0_0010,
        ST_SHIFT = 5'b0_0100,
        ST_CHECK = 5'b0_1000,
        ST_DONE = 5'b1_0000
    } afrc_state_e;
endpackage

// File: sim/afrc_adc_model.sv
// Behavioural converter at the far end of the readout link.
// Assumes SPI mode 0 from the host; the bench calls convert per sample set.
`timescale 1ns/1ps
module afrc_adc_model #(
    parameter int PERIOD = 1600,
    parameter logic [23:0] STATUS = 24'h05_0000
) (
    input wire logic clk,
    input wire logic sclk,
    input wire logic cs_n,
    output logic data_ready_n,
    output logic miso
);
    import afrc_pkg::*;
    logic [143:0] sh = '0;
    initial data_ready_n = 1'b1;
    initial miso = 1'b0;
    // First bit on select, next bit after each falling clock
    always @(negedge cs_n) miso = sh[143];
    always @(negedge sclk) begin
        if (!cs_n) begin
            sh = {sh[142:0], 1'b0};
            miso = sh[143];
        end
    end
    // Released line shows the inverse of the last bit
    always @(posedge cs_n) miso = ~miso;
    // CRC over the status and channel words
    function automatic logic [15:0] crc16(input logic [119:0] d);
        logic [15:0] c;
        c = CRC_INIT;
        for (int i = 119; i >= 0; i--) begin
            c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? CRC_POLY : 16'h0000);
        end
        return c;
    endfunction
    // One conversion: load frame, signal ready, wait one period
    task automatic convert(input afrc_samples_s s, input logic bad);
        logic [15:0] c;
        c = crc16({STATUS, s.ch0, s.ch1, s.ch2, s.ch3});
        if (bad) c = ~c;
        sh = {STATUS, s.ch0, s.ch1, s.ch2, s.ch3, c, 8'h00};
        @(posedge clk) data_ready_n <= 1'b0;
        for (int i = 0; i < 20 && cs_n; i++) @(posedge clk);
        @(posedge clk) data_ready_n <= 1'b1;
        repeat (PERIOD) @(posedge clk);
    endtask
endmodule

// File: sim/afrc_host_chk.sv
// Port assertions for the frame readout host.
// Assumes a bind onto afrc_host and a single clock domain.
`timescale 1ns/1ps
module afrc_host_chk (
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic DATA_READY_N,
    input afrc_pkg::afrc_spi_s SPI,
    input afrc_pkg::afrc_samples_s SAMPLES,
    input wire logic SAMPLES_VALID,
    input wire logic SAMPLES_READY,
    input wire logic CRC_ERROR,
    input wire logic CRC_ERROR_CLR,
    input wire logic BUSY
);
    import afrc_pkg::*;
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RST_N);
    logic [7:0] bits;
    // Counts link clock rises within one frame
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) bits <= 8'h00;
        else if (SPI.cs_n) bits <= 8'h00;
        else if ($rose(SPI.sclk)) bits <= bits + 8'h01;
    end
    sequence s_high_half;
        SPI.sclk [*4] ##1 !SPI.sclk;
    endsequence
    sequence s_frame_open;
        ##[2:10] $fell(SPI.cs_n);
    endsequence
    chk_sclk_idle_low: assert property (SPI.cs_n |-> !SPI.sclk)
        else $error("link clock moves outside a frame");
    chk_mosi_all_zero: assert property (!SPI.cs_n |-> !SPI.mosi)
        else $error("host sent a nonzero bit");
    chk_frame_bit_count: assert property ($rose(SPI.cs_n) |-> bits == 8'h90)
        else $error("frame length is not 144 bits");
    chk_frame_start: assert property ($fell(DATA_READY_N) && !BUSY |-> s_frame_open)
        else $error("no frame after data ready");
    chk_busy_in_frame: assert property (!SPI.cs_n |-> BUSY)
        else $error("select low while not busy");
    chk_sclk_half_period: assert property ($rose(SPI.sclk) |-> s_high_half)
        else $error("link clock high phase wrong");
    chk_samples_hold: assert property (SAMPLES_VALID && !SAMPLES_READY |=>
        SAMPLES_VALID && $stable(SAMPLES))
        else $error("samples changed before taken");
    chk_error_sticky: assert property (CRC_ERROR && !CRC_ERROR_CLR |=> CRC_ERROR)
        else $error("error flag dropped without clear");
    chk_error_clear: assert property (CRC_ERROR_CLR && !BUSY |=> !CRC_ERROR)
        else $error("error flag not cleared");
endmodule
bind afrc_host afrc_host_chk chk (.MCLK(MCLK), .RST_N(RST_N), .DATA_READY_N(DATA_READY_N),
    .SPI(SPI), .SAMPLES(SAMPLES), .SAMPLES_VALID(SAMPLES_VALID), .SAMPLES_READY(SAMPLES_READY),
    .CRC_ERROR(CRC_ERROR), .CRC_ERROR_CLR(CRC_ERROR_CLR), .BUSY(BUSY));

// File: sim/afrc_host_tb.sv
// Self-checking bench for the frame readout host.
// Assumes the converter model answers every conversion the bench starts.
`timescale 1ns/1ps
module afrc_host_tb;
    import afrc_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic sr = 1'b0;
    logic clr = 1'b0;
    logic data_ready_n_n, miso, sv, err, busy;
    afrc_spi_s spi;
    afrc_samples_s smp, f;
    int fails = 0;
    int compares = 0;
    int n;
    // System clock
    always #5 mclk = ~mclk;
    afrc_host uut (.MCLK(mclk), .RST_N(rst_n), .DATA_READY_N(data_ready_n_n), .MISO(miso),
        .SPI(spi), .SAMPLES(smp), .SAMPLES_VALID(sv), .SAMPLES_READY(sr),
        .CRC_ERROR(err), .CRC_ERROR_CLR(clr), .BUSY(busy));
    afrc_adc_model adc (.clk(mclk), .sclk(spi.sclk), .cs_n(spi.cs_n),
        .data_ready_n(data_ready_n_n), .miso(miso));
    // Compare and count
    task automatic check(input string nm, input logic [95:0] seen, input logic [95:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    function automatic afrc_samples_s mk(input logic [7:0] k);
        return {16'hC300, k, 16'hC200, k, 16'hC100, k, 16'hC000, k};
    endfunction
    // Pops every buffered set, keeping the first
    task automatic drain();
        n = 0;
        while (n < 40) begin
            @(negedge mclk);
            if (sv !== 1'b1) break;
            if (n == 0) f = smp;
            n++;
            @(posedge mclk) sr <= 1'b1;
            @(posedge mclk) sr <= 1'b0;
            @(posedge mclk);
        end
    endtask
    // Good frames reach the buffer one event later
    task automatic t_good();
        adc.convert(mk(8'h01), 1'b0);
        drain();
        adc.convert(mk(8'h02), 1'b0);
        drain();
        check("count", 96'(n), 96'd1);
        check("samples", f, mk(8'h01));
        check("error", 96'(err), 96'd0);
        $display("test good done");
    endtask
    // Bad checksum keeps the held set and raises the flag
    task automatic t_bad();
        adc.convert(mk(8'h03), 1'b1);
        check("error", 96'(err), 96'd1);
        drain();
        check("pushed", f, mk(8'h02));
        adc.convert(mk(8'h04), 1'b0);
        check("sticky", 96'(err), 96'd1);
        drain();
        check("held", 96'(n), 96'd0);
        @(posedge mclk) clr <= 1'b1;
        @(posedge mclk) clr <= 1'b0;
        @(negedge mclk);
        check("cleared", 96'(err), 96'd0);
        $display("test bad done");
    endtask
    // Consumer stalls until the buffer refuses, then drains it
    task automatic t_fill();
        for (int k = 5; k < 23; k++) adc.convert(mk(8'(k)), 1'b0);
        drain();
        check("depth", 96'(n), 96'(FIFO_DEPTH));
        check("oldest", f, mk(8'h04));
        $display("test fill done");
    endtask
    task automatic complete_run();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        t_good();
        t_bad();
        t_fill();
        complete_run();
    end
    // Watchdog
    initial begin
        repeat (50000) @(posedge mclk);
        fails++;
        complete_run();
    end
endmodule
